// ==== ctrl_port_device.sv ====
`timescale 1ns/1ps
module ctrl_port_device #(
  parameter int LOCK_CYC = ctrl_port_pkg::LOCK_WAIT_CYC,
  parameter int SCL_QTR = ctrl_port_pkg::SCL_QTR_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  ctrl_port_if.device bus,
  input wire logic chipAddrStrapLow,
  input wire logic bootFromEepromPin,
  output logic memWrEn,
  output logic [15:0] memWrAddr,
  output logic [2:0] memWrByte,
  output logic [7:0] memWrData,
  output logic [15:0] memRdAddr,
  output logic [2:0] memRdByte,
  input wire logic [7:0] memRdData,
  output logic spiMode,
  output logic bootBusy,
  output logic bootDone,
  output logic [6:0] twoWireAddr
);
  logic [5:0] syncd;
  logic latchS, sclkS, sdiS, sdaS, bootS, strapS;

  pin_sync #(.W(6)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({bus.latchN, bus.clkLine, bus.hostData, bus.dataLine, bootFromEepromPin, chipAddrStrapLow}),
    .dout(syncd)
  );
  assign {latchS, sclkS, sdiS, sdaS, bootS, strapS} = syncd;

  // shared pointer requests
  logic spiWr, spiAdv, spiHi, spiLo, bootWr, bootHi, bootLo;
  logic [7:0] spiByte;
  logic [7:0] rxByte_r, rxByte_nxt;

  // ---------------- spi slave ----------------
  logic latchD_r, latchD_nxt, sclkD_r, sclkD_nxt;
  logic [2:0] bitCnt_r, bitCnt_nxt;
  logic [1:0] byteCnt_r, byteCnt_nxt;
  logic [6:0] shIn_r, shIn_nxt;
  logic active_r, active_nxt, rw_r, rw_nxt, sdo_r, sdo_nxt;
  logic [15:0] subAddr_r;
  logic [2:0] wordByte_r;

  always_comb begin
    latchD_nxt = latchS;
    sclkD_nxt = sclkS;
    bitCnt_nxt = bitCnt_r;
    byteCnt_nxt = byteCnt_r;
    shIn_nxt = shIn_r;
    active_nxt = active_r;
    rw_nxt = rw_r;
    sdo_nxt = sdo_r;
    spiWr = 1'b0;
    spiAdv = 1'b0;
    spiHi = 1'b0;
    spiLo = 1'b0;
    spiByte = {shIn_r, sdiS};
    if (!spiMode || latchS) begin
      bitCnt_nxt = 3'h0;
      byteCnt_nxt = 2'h0;
      active_nxt = 1'b0;
    end else if (sclkS && !sclkD_r) begin
      shIn_nxt = spiByte[6:0];
      bitCnt_nxt = bitCnt_r + 3'h1;
      if (bitCnt_r == 3'h7) begin
        if (byteCnt_r != 2'h3) begin
          byteCnt_nxt = byteCnt_r + 2'h1;
        end
        case (byteCnt_r)
          2'h0: begin
            active_nxt = (spiByte[7:1] == (ctrl_port_pkg::SPI_CHIP_BASE | {6'h00, strapS}));
            rw_nxt = spiByte[0];
          end
          2'h1: spiHi = active_r;
          2'h2: spiLo = active_r;
          default: begin
            spiWr = active_r && !rw_r;
            spiAdv = active_r;
          end
        endcase
      end
    end else if (!sclkS && sclkD_r) begin
      sdo_nxt = memRdData[3'h7 - bitCnt_r];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      latchD_r <= 1'b1;
      sclkD_r <= 1'b0;
      bitCnt_r <= 3'h0;
      byteCnt_r <= 2'h0;
      shIn_r <= 7'h00;
      active_r <= 1'b0;
      rw_r <= 1'b0;
      sdo_r <= 1'b0;
    end else begin
      latchD_r <= latchD_nxt;
      sclkD_r <= sclkD_nxt;
      bitCnt_r <= bitCnt_nxt;
      byteCnt_r <= byteCnt_nxt;
      shIn_r <= shIn_nxt;
      active_r <= active_nxt;
      rw_r <= rw_nxt;
      sdo_r <= sdo_nxt;
    end
  end

  // ---------------- mode control and boot master ----------------
  ctrl_port_pkg::boot_t bus_r, bus_nxt;
  ctrl_port_pkg::msg_t msg_r, msg_nxt;
  logic spi_r, spi_nxt, done_r, done_nxt, scl_r, scl_nxt, sdaLow_r, sdaLow_nxt;
  logic isAddr_r, isAddr_nxt, endSeen_r, endSeen_nxt, dlyPend_r, dlyPend_nxt;
  logic [1:0] pulses_r, pulses_nxt, startCnt_r, startCnt_nxt, phase_r, phase_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] remain_r, remain_nxt;
  logic [15:0] dly_r, dly_nxt, qtr_r, qtr_nxt;
  logic [31:0] wait_r, wait_nxt;
  logic tick, endNow;

  assign tick = (qtr_r == 16'(SCL_QTR - 1));
  assign endNow = (msg_r == ctrl_port_pkg::M_TYPE) && ((rxByte_r == ctrl_port_pkg::MSG_END)
                  || (rxByte_r > ctrl_port_pkg::MSG_NOP));

  always_comb begin
    bus_nxt = bus_r;
    msg_nxt = msg_r;
    spi_nxt = spi_r;
    done_nxt = done_r;
    scl_nxt = scl_r;
    sdaLow_nxt = sdaLow_r;
    isAddr_nxt = isAddr_r;
    endSeen_nxt = endSeen_r;
    dlyPend_nxt = dlyPend_r;
    pulses_nxt = pulses_r;
    startCnt_nxt = startCnt_r;
    phase_nxt = phase_r;
    bit_nxt = bit_r;
    remain_nxt = remain_r;
    dly_nxt = dly_r;
    wait_nxt = wait_r;
    rxByte_nxt = rxByte_r;
    qtr_nxt = tick ? 16'h0000 : qtr_r + 16'h0001;
    bootWr = 1'b0;
    bootHi = 1'b0;
    bootLo = 1'b0;
    if (!spi_r && !bootBusy && latchD_r && !latchS) begin
      pulses_nxt = pulses_r + 2'h1;
      spi_nxt = (pulses_r == 2'(ctrl_port_pkg::MODE_SWITCH_PULSES - 1));
    end
    if (startCnt_r != 2'h3) begin
      startCnt_nxt = startCnt_r + 2'h1;
    end
    case (bus_r)
      ctrl_port_pkg::B_IDLE: begin
        // strap caught once the synchroniser has filled after reset
        if (startCnt_r == 2'h2 && bootS) begin
          bus_nxt = ctrl_port_pkg::B_WAIT;
        end
      end
      ctrl_port_pkg::B_WAIT: begin
        wait_nxt = wait_r + 32'h1;
        if (spi_r) begin
          bus_nxt = ctrl_port_pkg::B_IDLE;
        end else if (wait_r == 32'(LOCK_CYC - 1)) begin
          bus_nxt = ctrl_port_pkg::B_START;
          qtr_nxt = 16'h0000;
          phase_nxt = 2'h0;
        end
      end
      ctrl_port_pkg::B_START: if (tick) begin
        phase_nxt = phase_r + 2'h1;
        scl_nxt = (phase_r != 2'h2);
        sdaLow_nxt = (phase_r != 2'h0);
        if (phase_r == 2'h3) begin
          bus_nxt = ctrl_port_pkg::B_BIT;
          bit_nxt = 4'h0;
          isAddr_nxt = 1'b1;
        end
      end
      ctrl_port_pkg::B_BIT: if (tick) begin
        phase_nxt = phase_r + 2'h1;
        case (phase_r)
          2'h0: begin
            scl_nxt = 1'b0;
            if (bit_r == 4'h8) begin
              sdaLow_nxt = !isAddr_r && !endNow;
            end else begin
              sdaLow_nxt = isAddr_r && !ctrl_port_pkg::EEPROM_RD_ADDR[3'h7 - bit_r[2:0]];
            end
            if (bit_r == 4'h8 && !isAddr_r) begin
              case (msg_r)
                ctrl_port_pkg::M_TYPE: begin
                  endSeen_nxt = endNow;
                  if (rxByte_r == ctrl_port_pkg::MSG_WRITE) begin
                    msg_nxt = ctrl_port_pkg::M_LEN;
                  end else if (rxByte_r == ctrl_port_pkg::MSG_DELAY) begin
                    msg_nxt = ctrl_port_pkg::M_DLYH;
                  end
                end
                ctrl_port_pkg::M_LEN: begin
                  remain_nxt = (rxByte_r > ctrl_port_pkg::MSG_HDR_LEN) ? rxByte_r - ctrl_port_pkg::MSG_HDR_LEN : 8'h00;
                  msg_nxt = ctrl_port_pkg::M_CHIP;
                end
                ctrl_port_pkg::M_CHIP: msg_nxt = ctrl_port_pkg::M_SUBH;
                ctrl_port_pkg::M_SUBH: begin
                  bootHi = 1'b1;
                  msg_nxt = ctrl_port_pkg::M_SUBL;
                end
                ctrl_port_pkg::M_SUBL: begin
                  bootLo = 1'b1;
                  msg_nxt = (remain_r == 8'h00) ? ctrl_port_pkg::M_TYPE : ctrl_port_pkg::M_DATA;
                end
                ctrl_port_pkg::M_DATA: begin
                  bootWr = 1'b1;
                  remain_nxt = remain_r - 8'h01;
                  msg_nxt = (remain_r == 8'h01) ? ctrl_port_pkg::M_TYPE : ctrl_port_pkg::M_DATA;
                end
                ctrl_port_pkg::M_DLYH: begin
                  dly_nxt = {rxByte_r, 8'h00};
                  msg_nxt = ctrl_port_pkg::M_DLYL;
                end
                ctrl_port_pkg::M_DLYL: begin
                  dly_nxt = {dly_r[15:8], rxByte_r};
                  dlyPend_nxt = 1'b1;
                  msg_nxt = ctrl_port_pkg::M_TYPE;
                end
                default: msg_nxt = ctrl_port_pkg::M_TYPE;
              endcase
            end
          end
          2'h1: scl_nxt = 1'b1;
          2'h2: begin
            if (bit_r != 4'h8) begin
              rxByte_nxt = {rxByte_r[6:0], sdaS};
            end else if (isAddr_r && sdaS) begin
              endSeen_nxt = 1'b1;
            end
          end
          default: begin
            scl_nxt = 1'b0;
            bit_nxt = bit_r + 4'h1;
            if (bit_r == 4'h8) begin
              bit_nxt = 4'h0;
              isAddr_nxt = 1'b0;
              if (endSeen_r) begin
                bus_nxt = ctrl_port_pkg::B_STOP;
              end else if (dlyPend_r) begin
                bus_nxt = ctrl_port_pkg::B_DELAY;
                dlyPend_nxt = 1'b0;
              end
            end
          end
        endcase
      end
      ctrl_port_pkg::B_DELAY: if (tick) begin
        phase_nxt = phase_r + 2'h1;
        sdaLow_nxt = 1'b0;
        if (phase_r == 2'h3) begin
          if (dly_r == 16'h0000) begin
            bus_nxt = ctrl_port_pkg::B_BIT;
          end else begin
            dly_nxt = dly_r - 16'h0001;
          end
        end
      end
      ctrl_port_pkg::B_STOP: if (tick) begin
        phase_nxt = phase_r + 2'h1;
        scl_nxt = (phase_r != 2'h0);
        sdaLow_nxt = (phase_r < 2'h2);
        if (phase_r == 2'h3) begin
          bus_nxt = ctrl_port_pkg::B_DONE;
        end
      end
      ctrl_port_pkg::B_DONE: done_nxt = 1'b1;
      default: bus_nxt = ctrl_port_pkg::B_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bus_r <= ctrl_port_pkg::B_IDLE;
      msg_r <= ctrl_port_pkg::M_TYPE;
      spi_r <= 1'b0;
      done_r <= 1'b0;
      scl_r <= 1'b1;
      sdaLow_r <= 1'b0;
      isAddr_r <= 1'b0;
      endSeen_r <= 1'b0;
      dlyPend_r <= 1'b0;
      pulses_r <= 2'h0;
      startCnt_r <= 2'h0;
      phase_r <= 2'h0;
      bit_r <= 4'h0;
      remain_r <= 8'h00;
      dly_r <= 16'h0000;
      qtr_r <= 16'h0000;
      wait_r <= 32'h0;
      rxByte_r <= 8'h00;
    end else begin
      bus_r <= bus_nxt;
      msg_r <= msg_nxt;
      spi_r <= spi_nxt;
      done_r <= done_nxt;
      scl_r <= scl_nxt;
      sdaLow_r <= sdaLow_nxt;
      isAddr_r <= isAddr_nxt;
      endSeen_r <= endSeen_nxt;
      dlyPend_r <= dlyPend_nxt;
      pulses_r <= pulses_nxt;
      startCnt_r <= startCnt_nxt;
      phase_r <= phase_nxt;
      bit_r <= bit_nxt;
      remain_r <= remain_nxt;
      dly_r <= dly_nxt;
      qtr_r <= qtr_nxt;
      wait_r <= wait_nxt;
      rxByte_r <= rxByte_nxt;
    end
  end

  // ---------------- shared address pointer and write port ----------------
  logic [15:0] subAddr_nxt, wrAddr_nxt;
  logic [2:0] wordByte_nxt, wrByte_nxt;
  logic [7:0] wrData_nxt, ptrVal;
  logic wrEn_nxt;

  always_comb begin
    ptrVal = spi_r ? spiByte : rxByte_r;
    subAddr_nxt = subAddr_r;
    wordByte_nxt = wordByte_r;
    wrEn_nxt = spiWr || bootWr;
    wrAddr_nxt = memWrAddr;
    wrByte_nxt = memWrByte;
    wrData_nxt = memWrData;
    if (wrEn_nxt) begin
      wrAddr_nxt = subAddr_r;
      wrByte_nxt = wordByte_r;
      wrData_nxt = ptrVal;
    end
    if (spiHi || bootHi) begin
      subAddr_nxt = {ptrVal, subAddr_r[7:0]};
      wordByte_nxt = 3'h0;
    end else if (spiLo || bootLo) begin
      subAddr_nxt = {subAddr_r[15:8], ptrVal};
      wordByte_nxt = 3'h0;
    end else if (spiAdv || bootWr) begin
      if (wordByte_r == ctrl_port_pkg::word_len(subAddr_r) - 3'h1) begin
        wordByte_nxt = 3'h0;
        subAddr_nxt = subAddr_r + 16'h0001;
      end else begin
        wordByte_nxt = wordByte_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      subAddr_r <= 16'h0000;
      wordByte_r <= 3'h0;
      memWrEn <= 1'b0;
      memWrAddr <= 16'h0000;
      memWrByte <= 3'h0;
      memWrData <= 8'h00;
    end else begin
      subAddr_r <= subAddr_nxt;
      wordByte_r <= wordByte_nxt;
      memWrEn <= wrEn_nxt;
      memWrAddr <= wrAddr_nxt;
      memWrByte <= wrByte_nxt;
      memWrData <= wrData_nxt;
    end
  end

  assign memRdAddr = subAddr_r;
  assign memRdByte = wordByte_r;
  assign spiMode = spi_r;
  assign bootDone = done_r;
  assign bootBusy = (bus_r == ctrl_port_pkg::B_START) || (bus_r == ctrl_port_pkg::B_BIT)
                    || (bus_r == ctrl_port_pkg::B_DELAY) || (bus_r == ctrl_port_pkg::B_STOP);
  // strap high shares the serial input pin; ignored once booted
  assign twoWireAddr = done_r ? ctrl_port_pkg::BOOT_SLAVE_ADDR
                       : (ctrl_port_pkg::TWO_WIRE_BASE | {5'h00, sdiS, strapS});
  assign bus.devClkOut = scl_r;
  assign bus.devClkOe = bootBusy;
  assign bus.devDataOut = spi_r ? sdo_r : 1'b0;
  assign bus.devDataOe = sdaLow_r || (spi_r && !latchS && active_r && rw_r && byteCnt_r == 2'h3);
endmodule // ctrl_port_device

// ==== ctrl_port_pkg.sv ====
package ctrl_port_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CLK_HZ = CLK_MHZ * 1000000;
  localparam int MODE_SWITCH_PULSES = 3;
  localparam int LATCH_MIN_NS = 20;
  localparam int LATCH_MIN_CYC = (LATCH_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_WAIT_MS = 10;
  localparam int LOCK_WAIT_CYC = LOCK_WAIT_MS * CLK_MHZ * 1000;
  localparam int FS_HZ = 48000;
  localparam int SCL_PER_FS = 8;
  localparam int SCL_QTR_CYC = (CLK_HZ + FS_HZ * SCL_PER_FS * 4 - 1) / (FS_HZ * SCL_PER_FS * 4);
  localparam int SPI_HALF_CYC = 8;
  localparam int SPI_HDR_BYTES = 3;
  localparam logic [6:0] SPI_CHIP_BASE = 7'h00;
  localparam logic [6:0] TWO_WIRE_BASE = 7'h38;
  localparam logic [6:0] BOOT_SLAVE_ADDR = 7'h34;
  localparam logic [7:0] EEPROM_RD_ADDR = 8'ha1;
  localparam logic [7:0] MSG_END = 8'h00;
  localparam logic [7:0] MSG_WRITE = 8'h01;
  localparam logic [7:0] MSG_DELAY = 8'h02;
  localparam logic [7:0] MSG_NOP = 8'h03;
  localparam logic [7:0] MSG_HDR_LEN = 8'h03;
  localparam logic [15:0] PARAM_END = 16'h1000;
  localparam logic [15:0] PROG_END = 16'h2000;
  localparam logic [15:0] REG_END = 16'hf000;
  localparam logic [2:0] PARAM_LEN = 3'h4;
  localparam logic [2:0] PROG_LEN = 3'h5;
  localparam logic [2:0] REG_LEN = 3'h2;
  localparam logic [2:0] MISC_LEN = 3'h1;

  typedef enum {B_IDLE, B_WAIT, B_START, B_BIT, B_DELAY, B_STOP, B_DONE} boot_t;
  typedef enum {M_TYPE, M_LEN, M_CHIP, M_SUBH, M_SUBL, M_DATA, M_DLYH, M_DLYL} msg_t;
  typedef enum {H_IDLE, H_PLO, H_PHI, H_LEAD, H_LO, H_HI, H_TRAIL} host_t;

  // bytes per word at a subaddress
  function automatic logic [2:0] word_len(input logic [15:0] sub);
    if (sub < PARAM_END) begin
      return PARAM_LEN;
    end else if (sub < PROG_END) begin
      return PROG_LEN;
    end else if (sub < REG_END) begin
      return REG_LEN;
    end
    return MISC_LEN;
  endfunction
endpackage

// ==== ctrl_port_if.sv ====
`timescale 1ns/1ps
interface ctrl_port_if;
  logic latchN;
  logic hostClk;
  logic hostData;
  logic devClkOut;
  logic devClkOe;
  logic devDataOut;
  logic devDataOe;
  logic eepDataLow;
  logic clkLine;
  logic dataLine;

  // pulled up when nobody drives; the eeprom only pulls low
  assign clkLine = devClkOe ? devClkOut : hostClk;
  assign dataLine = (devDataOe ? devDataOut : 1'b1) & ~eepDataLow;

  modport device(input latchN, input clkLine, input hostData, input dataLine,
                 output devClkOut, output devClkOe, output devDataOut, output devDataOe);
  modport host(output latchN, output hostClk, output hostData, input dataLine);
endinterface

// ==== pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // pin_sync

// ==== ctrl_port_host.sv ====
`timescale 1ns/1ps
module ctrl_port_host #(
  parameter int HALF = ctrl_port_pkg::SPI_HALF_CYC,
  parameter int PULSE = ctrl_port_pkg::LATCH_MIN_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  ctrl_port_if.host bus,
  input wire logic modeReq,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdRead,
  input wire logic [6:0] cmdChip,
  input wire logic [15:0] cmdSub,
  input wire logic [7:0] cmdLen,
  input wire logic [7:0] wrData,
  output logic wrTake,
  output logic [7:0] rdData,
  output logic rdValid
);
  logic sdoS;
  ctrl_port_pkg::host_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt, sub_r, sub_nxt;
  logic [1:0] pulses_r, pulses_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [8:0] byte_r, byte_nxt, total_r, total_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, rd_nxt;
  logic latch_r, latch_nxt, sck_r, sck_nxt, mosi_r, mosi_nxt, read_r, read_nxt, rdv_nxt, take_nxt;
  logic halfEnd, nextLast;

  pin_sync #(.W(1)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din(bus.dataLine),
    .dout(sdoS)
  );

  assign halfEnd = (cnt_r == 16'(HALF - 1));
  assign nextLast = (byte_r + 9'h1 == total_r);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 16'h0001;
    sub_nxt = sub_r;
    pulses_nxt = pulses_r;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    total_nxt = total_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    rd_nxt = rdData;
    latch_nxt = latch_r;
    sck_nxt = sck_r;
    mosi_nxt = mosi_r;
    read_nxt = read_r;
    rdv_nxt = 1'b0;
    take_nxt = 1'b0;
    case (st_r)
      ctrl_port_pkg::H_IDLE: begin
        cnt_nxt = 16'h0000;
        if (modeReq) begin
          st_nxt = ctrl_port_pkg::H_PLO;
          pulses_nxt = 2'h0;
          latch_nxt = 1'b0;
        end else if (cmdValid) begin
          st_nxt = ctrl_port_pkg::H_LEAD;
          latch_nxt = 1'b0;
          read_nxt = cmdRead;
          sub_nxt = cmdSub;
          tx_nxt = {cmdChip, cmdRead};
          byte_nxt = 9'h000;
          bit_nxt = 3'h0;
          total_nxt = {1'b0, cmdLen} + 9'(ctrl_port_pkg::SPI_HDR_BYTES);
        end
      end
      ctrl_port_pkg::H_PLO: if (cnt_r == 16'(PULSE - 1)) begin
        st_nxt = ctrl_port_pkg::H_PHI;
        cnt_nxt = 16'h0000;
        latch_nxt = 1'b1;
      end
      ctrl_port_pkg::H_PHI: if (cnt_r == 16'(PULSE - 1)) begin
        cnt_nxt = 16'h0000;
        pulses_nxt = pulses_r + 2'h1;
        if (pulses_r == 2'(ctrl_port_pkg::MODE_SWITCH_PULSES - 1)) begin
          st_nxt = ctrl_port_pkg::H_IDLE;
        end else begin
          st_nxt = ctrl_port_pkg::H_PLO;
          latch_nxt = 1'b0;
        end
      end
      ctrl_port_pkg::H_LEAD: if (halfEnd) begin
        st_nxt = ctrl_port_pkg::H_LO;
        cnt_nxt = 16'h0000;
        mosi_nxt = tx_r[7];
      end
      ctrl_port_pkg::H_LO: if (halfEnd) begin
        st_nxt = ctrl_port_pkg::H_HI;
        cnt_nxt = 16'h0000;
        sck_nxt = 1'b1;
      end
      ctrl_port_pkg::H_HI: if (halfEnd) begin
        cnt_nxt = 16'h0000;
        sck_nxt = 1'b0;
        st_nxt = ctrl_port_pkg::H_LO;
        // the falling edge also shows the bit the device drove one fall earlier
        rx_nxt = {rx_r[6:0], sdoS};
        bit_nxt = bit_r + 3'h1;
        tx_nxt = {tx_r[6:0], 1'b0};
        mosi_nxt = tx_r[6];
        if (bit_r == 3'h7) begin
          rdv_nxt = read_r && (byte_r >= 9'(ctrl_port_pkg::SPI_HDR_BYTES));
          if (rdv_nxt) begin
            rd_nxt = {rx_r[6:0], sdoS};
          end
          byte_nxt = byte_r + 9'h1;
          if (nextLast) begin
            st_nxt = ctrl_port_pkg::H_TRAIL;
          end else begin
            case (byte_r)
              9'h000: tx_nxt = sub_r[15:8];
              9'h001: tx_nxt = sub_r[7:0];
              default: begin
                tx_nxt = read_r ? 8'h00 : wrData;
                take_nxt = !read_r;
              end
            endcase
            mosi_nxt = tx_nxt[7];
          end
        end
      end
      ctrl_port_pkg::H_TRAIL: if (halfEnd) begin
        st_nxt = ctrl_port_pkg::H_IDLE;
        latch_nxt = 1'b1;
      end
      default: st_nxt = ctrl_port_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= ctrl_port_pkg::H_IDLE;
      cnt_r <= 16'h0000;
      sub_r <= 16'h0000;
      pulses_r <= 2'h0;
      bit_r <= 3'h0;
      byte_r <= 9'h000;
      total_r <= 9'h000;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rdData <= 8'h00;
      latch_r <= 1'b1;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      read_r <= 1'b0;
      rdValid <= 1'b0;
      wrTake <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sub_r <= sub_nxt;
      pulses_r <= pulses_nxt;
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      total_r <= total_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rdData <= rd_nxt;
      latch_r <= latch_nxt;
      sck_r <= sck_nxt;
      mosi_r <= mosi_nxt;
      read_r <= read_nxt;
      rdValid <= rdv_nxt;
      wrTake <= take_nxt;
    end
  end

  assign cmdReady = (st_r == ctrl_port_pkg::H_IDLE) && !modeReq;
  assign bus.latchN = latch_r;
  assign bus.hostClk = sck_r;
  assign bus.hostData = mosi_r;
endmodule // ctrl_port_host

// ==== ctrl_port_properties.sv ====
`timescale 1ns/1ps
module ctrl_port_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic latchN,
  input wire logic hostClk,
  input wire logic hostData,
  input wire logic devClkOut,
  input wire logic devClkOe,
  input wire logic devDataOut,
  input wire logic devDataOe,
  input wire logic spiMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // the device sees the latch through two flops, so its output lags the latch rise
  property p_oe_framed; spiMode && devDataOe |-> !latchN || !$past(latchN) || !$past(latchN, 2); endproperty
  property p_idle_clk; latchN |-> !hostClk; endproperty
  property p_host_stable; !latchN && hostClk |-> $stable(hostData); endproperty
  property p_out_fall; spiMode && devDataOe && $past(devDataOe) && $changed(devDataOut) |-> !hostClk; endproperty
  property p_no_boot_spi; spiMode |-> !devClkOe; endproperty
  property p_boot_quiet; !devClkOe && !spiMode |-> !devDataOe; endproperty
  property p_scl_high; devClkOe && $rose(devClkOut) |=> devClkOut [*3]; endproperty
  property p_mode_pulse; $fell(latchN) && !spiMode |=> !latchN; endproperty
  a_oe_framed: assert property (p_oe_framed) else $error("data driven outside a frame");
  a_idle_clk: assert property (p_idle_clk) else $error("shift clock high while latch high");
  a_host_stable: assert property (p_host_stable) else $error("serial in moved while clock high");
  a_out_fall: assert property (p_out_fall) else $error("serial out moved while clock high");
  a_no_boot_spi: assert property (p_no_boot_spi) else $error("boot clock driven in spi mode");
  a_boot_quiet: assert property (p_boot_quiet) else $error("data driven outside boot and spi");
  a_scl_high: assert property (p_scl_high) else $error("boot clock high phase too short");
  a_mode_pulse: assert property (p_mode_pulse) else $error("latch pulse too short");
  c_spi: cover property ($rose(spiMode));
  c_read: cover property (spiMode && devDataOe);
  c_boot: cover property ($rose(devClkOe));
endmodule // ctrl_port_properties

// ==== test_control_port_spi_and_eeprom_boot.sv ====
`timescale 1ns/1ps
module test_control_port_spi_and_eeprom_boot;
  logic clk = 0, rstn = 0, strap = 0, bootPin = 1, modeReq = 0, cmdValid = 0, cmdRead = 0;
  logic [6:0] cmdChip = 0, twoWireAddr;
  logic [15:0] cmdSub = 0, memWrAddr, memRdAddr;
  logic [7:0] cmdLen = 0, wrData = 0, memRdData, rdData, memWrData;
  logic [2:0] memWrByte, memRdByte;
  logic memWrEn, spiMode, bootBusy, bootDone, cmdReady, wrTake, rdValid;
  int err_count = 0, comparisons = 0, wi;
  logic [26:0] expQ[$];
  logic [7:0] rdQ[$], wbuf[$];
  logic [15:0] subs[4] = '{16'h0ffe, 16'h1fff, 16'heffe, 16'hf000};
  ctrl_port_if bus();
  // eeprom model: acks its address, then sends rom bytes msb first and leaves each ack slot free
  logic eepLow = 1'b0;
  logic [7:0] eepAddr = 8'h00, rom[$];
  int eepFalls = 0, eepBit;
  assign bus.eepDataLow = eepLow;
  always @(posedge bus.clkLine) if (bus.devClkOe && eepFalls >= 2 && eepFalls < 10)
    eepAddr <= {eepAddr[6:0], bus.dataLine};
  always @(negedge bus.clkLine) if (bus.devClkOe) begin
    eepFalls++;
    eepBit = eepFalls - 2;
    #1 eepLow = (eepBit < 9) ? (eepBit == 8) : (eepBit % 9 != 8 && eepBit / 9 <= rom.size()
      && !rom[eepBit / 9 - 1][7 - eepBit % 9]);
  end
  assign memRdData = memRdAddr[7:0] + {5'h0, memRdByte};
  always #5 clk = ~clk;
  ctrl_port_device #(.LOCK_CYC(200), .SCL_QTR(4)) ctrl_port_device_inst (.clk(clk), .rstn(rstn), .bus(bus),
    .chipAddrStrapLow(strap), .bootFromEepromPin(bootPin), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
    .memWrByte(memWrByte), .memWrData(memWrData), .memRdAddr(memRdAddr), .memRdByte(memRdByte),
    .memRdData(memRdData), .spiMode(spiMode), .bootBusy(bootBusy), .bootDone(bootDone), .twoWireAddr(twoWireAddr));
  ctrl_port_host ctrl_port_host_inst (.clk(clk), .rstn(rstn), .bus(bus), .modeReq(modeReq), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdChip(cmdChip), .cmdSub(cmdSub), .cmdLen(cmdLen),
    .wrData(wrData), .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid));
  ctrl_port_properties ctrl_port_properties_inst (.clk(clk), .rstn(rstn), .latchN(bus.latchN),
    .hostClk(bus.hostClk), .hostData(bus.hostData), .devClkOut(bus.devClkOut), .devClkOe(bus.devClkOe),
    .devDataOut(bus.devDataOut), .devDataOe(bus.devDataOe), .spiMode(spiMode));
  task automatic give_verdict;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic int wl(input logic [15:0] s);
    return s < 16'h1000 ? 4 : s < 16'h2000 ? 5 : s < 16'hf000 ? 2 : 1;
  endfunction
  always @(posedge clk) if (memWrEn === 1'b1) check("write", {memWrAddr, memWrByte, memWrData},
    expQ.size() ? expQ.pop_front() : '1);
  always @(posedge clk) if (rdValid === 1'b1) check("read", rdData, rdQ.size() ? rdQ.pop_front() : 9'h100);
  always @(posedge clk) if (wrTake === 1'b1) begin
    wi <= wi + 1;
    wrData <= (wi + 1 < wbuf.size()) ? wbuf[wi + 1] : 8'h00;
  end
  task automatic do_reset;
    rstn = 0;
    repeat (6) @(posedge clk);
    #1 rstn = 1;
  endtask
  // model: a silent device leaves the pulled-up line reading all ones
  task automatic xfer(input logic rd, input logic [6:0] chip, input logic [15:0] sub, input int len);
    logic [15:0] a;
    int b, n;
    a = sub;
    b = 0;
    wbuf.delete();
    for (int k = 0; k < len; k++) begin
      wbuf.push_back(8'($urandom));
      if (chip != {6'h0, strap}) begin
        if (rd) rdQ.push_back(8'hff);
      end else if (rd) rdQ.push_back(a[7:0] + b[7:0]);
      else expQ.push_back({a, b[2:0], wbuf[k]});
      b++;
      if (b == wl(a)) begin
        b = 0;
        a++;
      end
    end
    wi = 0;
    wrData = wbuf[0];
    {cmdRead, cmdChip, cmdSub, cmdLen, cmdValid} = {rd, chip, sub, 8'(len), 1'b1};
    @(posedge clk);
    #1 cmdValid = 0;
    for (n = 0; n < 30000 && cmdReady !== 1'b1; n++) @(posedge clk);
    if (n == 30000) begin
      err_count++;
      give_verdict;
    end
    repeat (8) @(posedge clk);
    #1;
  endtask
  initial begin
    void'($urandom(32'hdf22fd98));
    strap = 1'($urandom);
    rom = '{8'h03, 8'h01, 8'h05, 8'h00, 8'h10, 8'h00, 8'($urandom), 8'($urandom), 8'h02, 8'h00, 8'h01, 8'h00};
    expQ.push_back({16'h1000, 3'h0, rom[6]});
    expQ.push_back({16'h1000, 3'h1, rom[7]});
    do_reset;
    // the host stays quiet until boot is over
    for (wi = 0; wi < 5000 && bootDone !== 1'b1; wi++) @(posedge clk);
    check("boot done", bootDone, 1'b1);
    check("eeprom address", eepAddr, 8'ha1);
    check("boot address", twoWireAddr, 7'h34);
    #1;
    do_reset;
    modeReq = 1;
    @(posedge clk);
    #1 modeReq = 0;
    repeat (600) @(posedge clk);
    #1;
    check("no boot", bootDone, 1'b0);
    check("spi mode", spiMode, 1'b1);
    foreach (subs[i]) begin
      xfer(0, {6'h0, strap}, subs[i], 9);
      xfer(1, {6'h0, strap}, subs[i], 9);
    end
    xfer(1, {6'h0, strap}, 16'($urandom), 5);
    xfer(1, {6'h0, ~strap}, 16'($urandom), 3);
    xfer(0, {6'h0, ~strap}, 16'h0100, 2);
    check("reads left", rdQ.size(), 0);
    check("writes left", expQ.size(), 0);
    give_verdict;
  end
endmodule // test_control_port_spi_and_eeprom_boot
